// File: inc/dct_pkg.sv
// Overview of operation
// - CKE falling outside a legal entry is a reset; mode state is wiped.
// - During reset every input except CKE is ignored.
// - A read burst cut by reset may finish once CKE returns high.
// - ODT acts only after termination is enabled and 12ns tMOD elapsed.
// - Termination timing is synchronous or asynchronous, chosen by power state and by entry and exit timing.
// - Termination never switches in self refresh; ODT frozen there.
// - CKE high or fast-exit power-down uses synchronous ODT delays.
// - Slow-exit or precharge power-down uses asynchronous ODT delays.
// - ODT falling too close before power-down entry uses async delay.
// - ODT rising too close before power-down entry uses async delay.
// - ODT falling within tAXPD of any power-down exit uses async delay.
// - ODT rising soon after slow or precharge exit uses async delay.
// - Extended mode write of A6/A2 changes nominal Rtt within tMOD.
package dct_pkg;

	// Power states of the device.
	typedef enum logic [2:0] {
		ST_ACTIVE,
		ST_PD_FAST,
		ST_PD_SLOW,
		ST_PD_PRE,
		ST_SELF_REF,
		ST_RESET
	} dct_state_t;

	// Command encodings as {CS#, RAS#, CAS#, WE#}.
	localparam logic [3:0] CMD_LM   = 4'h0;
	localparam logic [3:0] CMD_REF  = 4'h1;
	localparam logic [3:0] CMD_PRE  = 4'h2;
	localparam logic [3:0] CMD_ACT  = 4'h3;
	localparam logic [3:0] CMD_RD   = 4'h5;
	localparam logic [3:0] CMD_NOP  = 4'h7;

	// Mode register selection on the bank address and field positions.
	localparam logic [2:0] BA_MR      = 3'h0;
	localparam logic [2:0] BA_EMR     = 3'h1;
	localparam int         MR_PD_BIT  = 12;
	localparam int         EMR_RTT_HI = 6;
	localparam int         EMR_RTT_LO = 2;

	// Reset values of the mode state.
	localparam logic [1:0] RTT_RST     = 2'h0;
	localparam logic       MR_PD_RST   = 1'b0;
	localparam logic [7:0] AGE_SAT     = 8'hff;

	// Clock and mode update delay.
	localparam int         CLK_PERIOD_NS = 5;
	localparam int         T_MOD_NS      = 12;
	localparam logic [7:0] MOD_CYC =
		8'((T_MOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Termination timing counts in clocks, plain defaults.
	localparam logic [7:0] AOND_CYC  = 8'h02;
	localparam logic [7:0] AOFD_CYC  = 8'h03;
	localparam logic [7:0] AONPD_CYC = 8'h04;
	localparam logic [7:0] AOFPD_CYC = 8'h04;
	localparam logic [7:0] ANPD_CYC  = 8'h03;
	localparam logic [7:0] AXPD_CYC  = 8'h08;
	localparam logic [7:0] CKE_MIN_CYC = 8'h03;

endpackage

// File: core/dct_cke_odt_ctl.sv
module dct_cke_odt_ctl
	import dct_pkg::*;
#(
	parameter int BURST_LEN_P = 4
) (
	// Clock and reset.
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_N_I,
	// Control pins from the controller.
	input  wire logic        CKE_I,
	input  wire logic        ODT_I,
	input  wire logic        CS_N_I,
	input  wire logic        RAS_N_I,
	input  wire logic        CAS_N_I,
	input  wire logic        WE_N_I,
	input  wire logic [2:0]  BA_I,
	input  wire logic [13:0] ADDR_I,
	// Termination and state outputs.
	output logic             RTT_ON_O,
	output logic [1:0]       RTT_VAL_O,
	output logic             ODT_READY_O,
	output logic             ODT_ASYNC_O,
	output logic [2:0]       PWR_STATE_O,
	output logic             IN_RESET_O,
	output logic             READ_BURST_O
);

	// Only burst lengths of four and eight are served.
	if (BURST_LEN_P != 4 && BURST_LEN_P != 8) begin : g_chk
		$error("BURST_LEN_P must be 4 or 8.");
	end

	localparam logic [7:0] BURST_CYC = 8'(BURST_LEN_P / 2);

	dct_state_t  state_reg;
	dct_state_t  state_next;
	logic        bank_open_reg;
	logic        mr_slow_reg;
	logic [7:0]  burst_cnt_reg;
	logic [1:0]  rtt_pend_reg;
	logic [1:0]  rtt_val_reg;
	logic [7:0]  mod_cnt_reg;
	logic        odt_ready_reg;
	logic        odt_prev_reg;
	logic [7:0]  odt_age_reg;
	logic [7:0]  exit_age_reg;
	logic        exit_slow_reg;
	logic [7:0]  dly_cnt_reg;
	logic        target_reg;
	logic        rtt_on_reg;
	logic        async_reg;

	logic [3:0]  cmd;
	logic        cmd_take;
	logic        idle_cmd;
	logic        enter_reset;
	logic        pd_entry;
	logic        pd_exit;
	logic        emr_write;
	logic        odt_acc;
	logic        exit_near;
	logic        edge_async;

	// Commands count only in active state with CKE high.
	assign cmd       = {CS_N_I, RAS_N_I, CAS_N_I, WE_N_I};
	assign cmd_take  = state_reg == ST_ACTIVE && CKE_I && !CS_N_I;
	assign idle_cmd  = CS_N_I || cmd == CMD_NOP;
	assign emr_write = cmd_take && cmd == CMD_LM && BA_I == BA_EMR;

	// A CKE drop with a running burst, or with a command other than NOP, deselect or a legal self-refresh entry, is a reset.
	assign enter_reset = state_reg == ST_ACTIVE && !CKE_I &&
		state_next == ST_RESET;
	assign pd_entry = state_reg == ST_ACTIVE && !CKE_I &&
		(state_next == ST_PD_FAST || state_next == ST_PD_SLOW ||
		 state_next == ST_PD_PRE);
	assign pd_exit = CKE_I && (state_reg == ST_PD_FAST ||
		state_reg == ST_PD_SLOW || state_reg == ST_PD_PRE);

	// ODT changes are taken only once enabled and outside reset and refresh.
	assign odt_acc = odt_ready_reg && ODT_I != odt_prev_reg &&
		state_reg != ST_SELF_REF && state_reg != ST_RESET;
	assign exit_near = state_reg == ST_ACTIVE && exit_age_reg < AXPD_CYC;

	// Timing class of an accepted ODT change.
	always_comb begin
		edge_async = 1'b0;
		if (state_reg == ST_PD_SLOW || state_reg == ST_PD_PRE) begin
			edge_async = 1'b1;
		end else if (pd_entry) begin
			edge_async = 1'b1;
		end else if (exit_near && !ODT_I) begin
			edge_async = 1'b1;
		end else if (exit_near && exit_slow_reg) begin
			edge_async = 1'b1;
		end
	end

	// Next power state from CKE and the command on the pins.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_ACTIVE: begin
				if (!CKE_I) begin
					if (!CS_N_I && cmd == CMD_REF && !bank_open_reg &&
					    burst_cnt_reg == 8'h00) begin
						state_next = ST_SELF_REF;
					end else if (idle_cmd && burst_cnt_reg == 8'h00) begin
						if (!bank_open_reg) begin
							state_next = ST_PD_PRE;
						end else if (mr_slow_reg) begin
							state_next = ST_PD_SLOW;
						end else begin
							state_next = ST_PD_FAST;
						end
					end else begin
						state_next = ST_RESET;
					end
				end
			end
			ST_PD_FAST, ST_PD_SLOW, ST_PD_PRE, ST_SELF_REF, ST_RESET: begin
				if (CKE_I) begin
					state_next = ST_ACTIVE;
				end
			end
			default: state_next = ST_ACTIVE;
		endcase
	end

	// Power state register.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			state_reg <= ST_ACTIVE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Open-bank tracking and the power-down exit kind in bit 12.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I || enter_reset) begin
			bank_open_reg <= 1'b0;
			mr_slow_reg   <= MR_PD_RST;
		end else if (cmd_take) begin
			if (cmd == CMD_ACT) begin
				bank_open_reg <= 1'b1;
			end else if (cmd == CMD_PRE) begin
				bank_open_reg <= 1'b0;
			end else if (cmd == CMD_LM && BA_I == BA_MR) begin
				mr_slow_reg <= ADDR_I[MR_PD_BIT];
			end
		end
	end

	// Read burst counter; frozen while CKE is low, resumes afterwards.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			burst_cnt_reg <= 8'h00;
		end else if (cmd_take && cmd == CMD_RD) begin
			burst_cnt_reg <= BURST_CYC;
		end else if (CKE_I && burst_cnt_reg != 8'h00) begin
			burst_cnt_reg <= burst_cnt_reg - 8'h01;
		end
	end

	// Extended mode write stages the Rtt value until tMOD elapses.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I || enter_reset) begin
			rtt_pend_reg  <= RTT_RST;
			rtt_val_reg   <= RTT_RST;
			mod_cnt_reg   <= 8'h00;
			odt_ready_reg <= 1'b0;
		end else if (emr_write) begin
			rtt_pend_reg  <= {ADDR_I[EMR_RTT_HI], ADDR_I[EMR_RTT_LO]};
			mod_cnt_reg   <= MOD_CYC;
			odt_ready_reg <= 1'b0;
		end else if (mod_cnt_reg == 8'h01) begin
			rtt_val_reg   <= rtt_pend_reg;
			mod_cnt_reg   <= 8'h00;
			odt_ready_reg <= rtt_pend_reg != RTT_RST;
		end else if (mod_cnt_reg != 8'h00) begin
			mod_cnt_reg <= mod_cnt_reg - 8'h01;
		end
	end

	// Ages since the last ODT change and the last power-down exit.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I || enter_reset) begin
			odt_prev_reg  <= 1'b0;
			odt_age_reg   <= AGE_SAT;
			exit_age_reg  <= AGE_SAT;
			exit_slow_reg <= 1'b0;
		end else begin
			if (odt_acc) begin
				odt_prev_reg <= ODT_I;
				odt_age_reg  <= 8'h00;
			end else if (odt_age_reg != AGE_SAT) begin
				odt_age_reg <= odt_age_reg + 8'h01;
			end
			if (pd_exit) begin
				exit_age_reg  <= 8'h00;
				exit_slow_reg <= state_reg != ST_PD_FAST;
			end else if (exit_age_reg != AGE_SAT) begin
				exit_age_reg <= exit_age_reg + 8'h01;
			end
		end
	end

	// Termination switch with synchronous or asynchronous delay.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I || enter_reset) begin
			dly_cnt_reg <= 8'h00;
			target_reg  <= 1'b0;
			rtt_on_reg  <= 1'b0;
			async_reg   <= 1'b0;
		end else if (!odt_ready_reg) begin
			dly_cnt_reg <= 8'h00;
			rtt_on_reg  <= 1'b0;
		end else if (odt_acc) begin
			target_reg <= ODT_I;
			async_reg  <= edge_async;
			if (edge_async) begin
				dly_cnt_reg <= ODT_I ? AONPD_CYC : AOFPD_CYC;
			end else begin
				dly_cnt_reg <= ODT_I ? AOND_CYC : AOFD_CYC;
			end
		end else if (pd_entry && dly_cnt_reg != 8'h00 &&
		             odt_age_reg < ANPD_CYC) begin
			async_reg   <= 1'b1;
			dly_cnt_reg <= target_reg ? AONPD_CYC : AOFPD_CYC;
		end else if (state_reg != ST_SELF_REF && dly_cnt_reg != 8'h00) begin
			dly_cnt_reg <= dly_cnt_reg - 8'h01;
			if (dly_cnt_reg == 8'h01) begin
				rtt_on_reg <= target_reg;
			end
		end
	end

	// Outputs from flip-flops; IN_RESET_O and READ_BURST_O decoded from them.
	assign RTT_ON_O     = rtt_on_reg;
	assign RTT_VAL_O    = rtt_val_reg;
	assign ODT_READY_O  = odt_ready_reg;
	assign ODT_ASYNC_O  = async_reg;
	assign PWR_STATE_O  = state_reg;
	assign IN_RESET_O   = state_reg == ST_RESET;
	assign READ_BURST_O = burst_cnt_reg != 8'h00;

	// Checks on the block's own behaviour.
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);

	property p_reset_wipe;
		state_reg == ST_ACTIVE && !CKE_I && !CS_N_I && cmd == CMD_LM
		|=> IN_RESET_O && RTT_VAL_O == RTT_RST && !ODT_READY_O;
	endproperty
	a_reset_wipe: assert property (p_reset_wipe)
		else $error("Reset entry did not wipe mode state.");

	property p_reset_ignore;
		IN_RESET_O && !CKE_I
		|=> IN_RESET_O && $stable(RTT_VAL_O) && $stable(burst_cnt_reg)
			&& !RTT_ON_O;
	endproperty
	a_reset_ignore: assert property (p_reset_ignore)
		else $error("Inputs acted during reset.");

	property p_burst_resume;
		IN_RESET_O && CKE_I && burst_cnt_reg > 8'h01
		|=> !IN_RESET_O && READ_BURST_O;
	endproperty
	a_burst_resume: assert property (p_burst_resume)
		else $error("Interrupted burst did not resume.");

	property p_odt_gate;
		!ODT_READY_O |=> !RTT_ON_O;
	endproperty
	a_odt_gate: assert property (p_odt_gate)
		else $error("Termination on while ODT not enabled.");

	property p_rtt_update;
		emr_write ##1 !emr_write [*3]
		|=> RTT_VAL_O == $past(rtt_pend_reg) && !$past(ODT_READY_O, 2);
	endproperty
	a_rtt_update: assert property (p_rtt_update)
		else $error("Rtt value not updated within tMOD.");

	property p_sr_frozen;
		state_reg == ST_SELF_REF && $past(state_reg) == ST_SELF_REF
		|-> $stable(RTT_ON_O) && $stable(ODT_ASYNC_O);
	endproperty
	a_sr_frozen: assert property (p_sr_frozen)
		else $error("Termination switched in self refresh.");

	property p_sync_class;
		odt_acc && state_reg == ST_ACTIVE && CKE_I &&
		exit_age_reg >= AXPD_CYC
		|=> !ODT_ASYNC_O && (dly_cnt_reg == AOND_CYC ||
			dly_cnt_reg == AOFD_CYC);
	endproperty
	a_sync_class: assert property (p_sync_class)
		else $error("Synchronous delay not applied.");

	property p_async_pd;
		odt_acc && (state_reg == ST_PD_SLOW || state_reg == ST_PD_PRE)
		|=> ODT_ASYNC_O;
	endproperty
	a_async_pd: assert property (p_async_pd)
		else $error("Asynchronous delay not applied in power-down.");

	property p_entry_late;
		pd_entry && dly_cnt_reg != 8'h00 && odt_age_reg < ANPD_CYC
		|=> ODT_ASYNC_O;
	endproperty
	a_entry_late: assert property (p_entry_late)
		else $error("Late ODT before power-down kept sync delay.");

	property p_exit_off;
		odt_acc && !ODT_I && exit_near |=> ODT_ASYNC_O;
	endproperty
	a_exit_off: assert property (p_exit_off)
		else $error("Early turn-off after exit kept sync delay.");

	property p_fast_exit_on;
		odt_acc && ODT_I && exit_near && !exit_slow_reg && CKE_I
		|=> !ODT_ASYNC_O;
	endproperty
	a_fast_exit_on: assert property (p_fast_exit_on)
		else $error("Turn-on after fast exit used async delay.");

	property p_pd_slow;
		state_reg == ST_ACTIVE && !CKE_I && idle_cmd && bank_open_reg &&
		mr_slow_reg && burst_cnt_reg == 8'h00
		|=> PWR_STATE_O == ST_PD_SLOW;
	endproperty
	a_pd_slow: assert property (p_pd_slow)
		else $error("Slow-exit power-down not entered.");

	c_self_ref: cover property (state_reg == ST_ACTIVE ##1
		state_reg == ST_SELF_REF);
	c_reset_resume: cover property (IN_RESET_O && READ_BURST_O ##1
		!IN_RESET_O);
	c_emr_ready: cover property (emr_write ##4 ODT_READY_O);
	c_async_on: cover property (odt_acc && edge_async && ODT_I);

endmodule

// File: testbench/dct_ctl_model.sv
module dct_ctl_model
	import dct_pkg::*;
(
	// Clock from the bench.
	input  wire logic        clk_i,
	// Pins driven towards the device.
	output logic             cke_o,
	output logic             odt_o,
	output logic [3:0]       cmd_o,
	output logic [2:0]       ba_o,
	output logic [13:0]      addr_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle pins at time zero: clock enabled, termination off, NOP.
	initial begin
		cke_o  = 1'b1;
		odt_o  = 1'b0;
		cmd_o  = CMD_NOP;
		ba_o   = 3'h0;
		addr_o = 14'h0000;
	end

	// Every task is entered and left at a falling edge.
	// One command for one edge, then NOP with inverted don't-care bits.
	task automatic cmd(input logic [3:0] c, input logic [2:0] b,
		input logic [13:0] a);
		cmd_o  = c;
		ba_o   = b;
		addr_o = a;
		@(negedge clk_i);
		cmd_o  = CMD_NOP;
		ba_o   = ~b;
		addr_o = ~a;
	endtask

	// Moves CKE, optionally holding it for the minimum time.
	task automatic set_cke(input logic v, input logic hold);
		cke_o = v;
		if (hold) begin
			repeat (CKE_MIN_CYC) @(negedge clk_i);
		end
	endtask

	// Moves the termination request.
	task automatic set_odt(input logic v);
		odt_o = v;
	endtask
endmodule

// File: testbench/dram_cke_reset_odt_timing_bench.sv
module dram_cke_reset_odt_timing_bench import dct_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk;
	logic        rst_n;
	logic        cke;
	logic        odt;
	logic [3:0]  cmd;
	logic [2:0]  ba;
	logic [13:0] addr;
	logic        rtt_on;
	logic [1:0]  rtt_val;
	logic        odt_ready;
	logic        odt_async;
	logic [2:0]  pwr_state;
	logic        in_reset;
	logic        read_burst;
	int          err_count = 0;
	int          n_tests = 0;

	// Longer burst so the reset lands while data still remains.
	dct_cke_odt_ctl #(.BURST_LEN_P(8)) dut (
		.CLK_SYS_I(clk), .RST_N_I(rst_n), .CKE_I(cke), .ODT_I(odt),
		.CS_N_I(cmd[3]), .RAS_N_I(cmd[2]), .CAS_N_I(cmd[1]),
		.WE_N_I(cmd[0]), .BA_I(ba), .ADDR_I(addr), .RTT_ON_O(rtt_on),
		.RTT_VAL_O(rtt_val), .ODT_READY_O(odt_ready),
		.ODT_ASYNC_O(odt_async), .PWR_STATE_O(pwr_state),
		.IN_RESET_O(in_reset), .READ_BURST_O(read_burst)
	);

	dct_ctl_model ctl (
		.clk_i(clk), .cke_o(cke), .odt_o(odt), .cmd_o(cmd),
		.ba_o(ba), .addr_o(addr)
	);

	// Clock at 200 MHz, never stopped, also across the CKE-low reset.
	initial clk = 1'b0;
	always #2.5 clk = ~clk;

	// Compares single flags.
	task automatic chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %h vs %h", $time, got, exp);
		end
	endtask

	// Compares multi-bit fields.
	task automatic chk_fld(input logic [2:0] got, input logic [2:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %h vs %h", $time, got, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test;
		$display("checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Moves ODT, checks the delay class and the exact switching edge.
	task automatic odt_step(input logic v, input logic as, input int n);
		ctl.set_odt(v);
		@(posedge clk);
		for (int k = 1; k <= n; k++) begin
			@(posedge clk);
			#1;
			if (k == 1) chk_bit(odt_async, as);
			chk_bit(rtt_on, (k == n) ? v : ~v);
		end
		@(negedge clk);
	endtask

	// Termination write: value and readiness appear after the mode delay.
	// The write edge is not counted; readiness comes on the third clock after it.
	task automatic t_emr;
		ctl.cmd(CMD_LM, BA_EMR, 14'h0040);
		repeat (MOD_CYC - 8'h01) @(posedge clk);
		#1;
		chk_bit(odt_ready, 1'b0);
		@(posedge clk);
		#1;
		chk_bit(odt_ready, 1'b1);
		chk_fld({1'b0, rtt_val}, 3'h2);
		@(negedge clk);
	endtask

	// Slow-exit power-down, then early and late ODT after the exit.
	task automatic t_slow;
		ctl.cmd(CMD_LM, BA_MR, 14'h1000);
		ctl.cmd(CMD_ACT, 3'h0, 14'h0000);
		ctl.set_cke(1'b0, 1'b1);
		chk_fld(pwr_state, 3'(ST_PD_SLOW));
		odt_step(1'b1, 1'b1, AONPD_CYC);
		odt_step(1'b0, 1'b1, AOFPD_CYC);
		ctl.set_cke(1'b1, 1'b1);
		chk_fld(pwr_state, 3'(ST_ACTIVE));
		odt_step(1'b1, 1'b1, AONPD_CYC);
		repeat (AXPD_CYC) @(negedge clk);
		odt_step(1'b0, 1'b0, AOFD_CYC);
	endtask

	// Fast-exit power-down, early turn-off after exit, late ODT drop.
	task automatic t_fast;
		ctl.cmd(CMD_LM, BA_MR, 14'h0000);
		ctl.set_cke(1'b0, 1'b1);
		chk_fld(pwr_state, 3'(ST_PD_FAST));
		odt_step(1'b1, 1'b0, AOND_CYC);
		ctl.set_cke(1'b1, 1'b1);
		odt_step(1'b0, 1'b1, AOFPD_CYC);
		repeat (AXPD_CYC) @(negedge clk);
		odt_step(1'b1, 1'b0, AOND_CYC);
		ctl.set_cke(1'b0, 1'b0);
		odt_step(1'b0, 1'b1, AOFPD_CYC);
		chk_fld(pwr_state, 3'(ST_PD_FAST));
		ctl.set_cke(1'b1, 1'b1);
	endtask

	// Precharge power-down, then self refresh with ODT held frozen.
	task automatic t_pre_sr;
		ctl.cmd(CMD_PRE, 3'h0, 14'h0400);
		ctl.set_cke(1'b0, 1'b1);
		chk_fld(pwr_state, 3'(ST_PD_PRE));
		ctl.set_cke(1'b1, 1'b1);
		ctl.set_cke(1'b0, 1'b0);
		ctl.cmd(CMD_REF, 3'h0, 14'h0000);
		repeat (2) @(negedge clk);
		chk_fld(pwr_state, 3'(ST_SELF_REF));
		ctl.set_odt(1'b1);
		repeat (6) @(negedge clk);
		chk_bit(rtt_on, 1'b0);
		ctl.set_odt(1'b0);
		ctl.set_cke(1'b1, 1'b1);
		chk_fld(pwr_state, 3'(ST_ACTIVE));
	endtask

	// CKE drop in mid-read: state wiped, inputs ignored, burst resumes.
	task automatic t_reset;
		ctl.cmd(CMD_RD, 3'h0, 14'h0000);
		ctl.set_cke(1'b0, 1'b1);
		chk_bit(in_reset, 1'b1);
		chk_fld(pwr_state, 3'(ST_RESET));
		chk_fld({1'b0, rtt_val}, 3'h0);
		chk_bit(odt_ready, 1'b0);
		ctl.set_odt(1'b1);
		repeat (4) @(negedge clk);
		chk_bit(rtt_on, 1'b0);
		chk_bit(read_burst, 1'b1);
		ctl.set_odt(1'b0);
		ctl.set_cke(1'b1, 1'b1);
		repeat (4) @(negedge clk);
		chk_bit(in_reset, 1'b0);
		chk_bit(read_burst, 1'b0);
	endtask

	// Reset, reset values, then the scenarios in turn.
	initial begin
		rst_n = 1'b0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk_fld(pwr_state, 3'(ST_ACTIVE));
		chk_bit(odt_ready, 1'b0);
		ctl.set_odt(1'b1);
		repeat (6) @(negedge clk);
		chk_bit(rtt_on, 1'b0);
		ctl.set_odt(1'b0);
		@(negedge clk);
		t_emr();
		odt_step(1'b1, 1'b0, AOND_CYC);
		odt_step(1'b0, 1'b0, AOFD_CYC);
		t_slow();
		t_fast();
		t_pre_sr();
		t_reset();
		stop_test();
	end

	// Cuts a hang short well beyond the expected run length.
	initial begin
		#20000;
		err_count++;
		stop_test();
	end
endmodule
